/* verilog/idt_pkg.sv */
/*
 Shared constants, types and decode functions for the instruction decode and timing block.
 Assumes a 14-bit instruction word and a core clock equal to the oscillator clock.
*/
package idt_pkg;

   // ---------------------------------------------------------------
   // Widths and timing
   // ---------------------------------------------------------------
   localparam int WORD_W      = 14;
   localparam int PHASE_COUNT = 4;
   localparam int ADDR_W      = 7;
   localparam int LIT_W       = 11;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DEST_POS    = 7;
   localparam int BIT_LSB     = 7;
   localparam int PTR_SEL_POS = 2;

   // ---------------------------------------------------------------
   // Classes and encodings
   // ---------------------------------------------------------------
   localparam logic [1:0]  CLASS_BYTE   = 2'h0;
   localparam logic [1:0]  CLASS_BIT    = 2'h1;
   localparam logic [1:0]  CLASS_LITCTL = 2'h2;
   localparam logic [13:0] OP_NOP       = 14'h0000;
   localparam logic [13:0] OP_RETURN    = 14'h0008;
   localparam logic [13:0] OP_IRQ_RET   = 14'h0009;
   localparam logic [13:0] OP_CALL_W    = 14'h000a;
   localparam logic [13:0] OP_BRANCH_W  = 14'h000b;
   localparam logic [9:0]  OP10_PTRMOVE = 10'h001;
   localparam logic [4:0]  OP5_BR_REL   = 5'h19;
   localparam logic [3:0]  OP4_SKIP_CLR = 4'h6;
   localparam logic [3:0]  OP4_SKIP_SET = 4'h7;
   localparam logic [1:0]  OP2_JUMP     = 2'h2;
   localparam logic [5:0]  OP6_ADDWF    = 6'h07;
   localparam logic [5:0]  OP6_SUBWF    = 6'h02;
   localparam logic [5:0]  OP6_RRF      = 6'h0c;
   localparam logic [5:0]  OP6_RLF      = 6'h0d;
   localparam logic [5:0]  OP6_SWAPF    = 6'h0e;
   localparam logic [5:0]  OP6_DEC_SKIP = 6'h0b;
   localparam logic [5:0]  OP6_INC_SKIP = 6'h0f;
   localparam logic [5:0]  OP6_ADDC     = 6'h3d;
   localparam logic [5:0]  OP6_SUBB     = 6'h3b;
   localparam logic [5:0]  OP6_LSL      = 6'h35;
   localparam logic [5:0]  OP6_LSR      = 6'h36;
   localparam logic [5:0]  OP6_ASR      = 6'h37;
   localparam logic [5:0]  OP6_RET_LIT  = 6'h34;
   localparam logic [5:0]  OP6_MOVLW    = 6'h30;
   localparam logic [5:0]  OP6_IORLW    = 6'h38;
   localparam logic [5:0]  OP6_ANDLW    = 6'h39;
   localparam logic [5:0]  OP6_XORLW    = 6'h3a;
   localparam logic [5:0]  OP6_SUBLW    = 6'h3c;
   localparam logic [5:0]  OP6_ADDLW    = 6'h3e;
   localparam logic [6:0]  IND0_ADDR    = 7'h00;
   localparam logic [6:0]  IND1_ADDR    = 7'h01;

   // Status mask is {carry, digit_carry_flag, zero}.
   localparam logic [2:0]  STAT_NONE    = 3'h0;
   localparam logic [2:0]  STAT_Z       = 3'h1;
   localparam logic [2:0]  STAT_C       = 3'h4;
   localparam logic [2:0]  STAT_CZ      = 3'h5;
   localparam logic [2:0]  STAT_ALL     = 3'h7;

   typedef enum logic [1:0] {ST_EXEC, ST_INDIRECT, ST_NOP} idt_state_e;

   function automatic logic idt_is_byte(input logic [13:0] w);
      logic [5:0] op;
      op = w[13:8];
      idt_is_byte = (w[13:12] == 2'h0 && (w[11:8] != 4'h0 || w[7])) ||
                    op == OP6_ADDC || op == OP6_SUBB || op == OP6_LSL || op == OP6_LSR || op == OP6_ASR;
   endfunction

   function automatic logic idt_is_skip(input logic [13:0] w);
      idt_is_skip = w[13:8] == OP6_DEC_SKIP || w[13:8] == OP6_INC_SKIP ||
                    w[13:10] == OP4_SKIP_CLR || w[13:10] == OP4_SKIP_SET;
   endfunction

   function automatic logic idt_fixed_two(input logic [13:0] w);
      idt_fixed_two = w[13:12] == OP2_JUMP || w[13:9] == OP5_BR_REL || w[13:8] == OP6_RET_LIT ||
                      w == OP_RETURN || w == OP_IRQ_RET || w == OP_CALL_W || w == OP_BRANCH_W;
   endfunction

   function automatic logic [2:0] idt_status(input logic [13:0] w);
      case (w[13:8])
         OP6_ADDWF, OP6_SUBWF, OP6_ADDC, OP6_SUBB, OP6_ADDLW, OP6_SUBLW: idt_status = STAT_ALL;
         OP6_LSL, OP6_LSR, OP6_ASR:                                     idt_status = STAT_CZ;
         OP6_RLF, OP6_RRF:                                              idt_status = STAT_C;
         OP6_ANDLW, OP6_IORLW, OP6_XORLW:                               idt_status = STAT_Z;
         default: begin
            if (w[13:12] == 2'h0 && w[11:8] != 4'h0 && w[13:8] != OP6_SWAPF &&
                !idt_is_skip(w))
               idt_status = STAT_Z;
            else
               idt_status = STAT_NONE;
         end
      endcase
   endfunction

endpackage

/* verilog/idt_phase.sv */
/*
 Phase counter that splits each instruction cycle into oscillator clock phases.
 Assumes CLK is the oscillator clock and RESET is asynchronous, active high.
*/
`timescale 1ns/100ps
module idt_phase #(
   parameter int PHASES = 4,
   parameter int PH_W   = 2
) (
   input  wire logic            clk,
   input  wire logic            reset,
   output logic      [PH_W-1:0] phase,
   output logic                 wrap
);

   logic [PH_W-1:0] phase_reg;
   logic [PH_W-1:0] phase_next;

   initial begin
      if (PHASES < 2 || (1 << PH_W) < PHASES)
         $error("idt_phase: phase count does not fit its counter");
   end

   always_comb begin
      if (phase_reg == PH_W'(PHASES - 1))
         phase_next = '0;
      else
         phase_next = phase_reg + PH_W'(1);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         phase_reg <= '0;
      else
         phase_reg <= phase_next;
   end

   assign phase = phase_reg;
   assign wrap  = (phase_reg == PH_W'(PHASES - 1));

endmodule

/* verilog/idt_decoder.sv */
/*
 Instruction register, field decoder and cycle sequencer of a small 8-bit core.
 Assumes the fetch path presents the next word on INSTR_WORD by the last phase of an
 instruction, and the datapath gives the skip result and pointer region bits synchronously.
*/
`timescale 1ns/100ps
// Contract
// - Accept 14-bit words holding opcode and operands.
// - Sort into byte, bit, literal/control classes.
// - One cycle, except listed two/three-cycle cases.
// - Both subroutine calls take two cycles.
// - All three returns take two cycles.
// - Jumps, branches, taken skips take two cycles.
// - Indirect access to program memory adds cycle.
// - Four oscillator clocks per instruction cycle.
// - File operands always read, modify, then store; bit tests only read and store nothing.
// - File address field spans 0x00 to 0x7F.
// - Bit field selects one of eight bits.
// - Destination bit: 0 working, 1 file.
// - Don't-care bits do not change decoding.
// - Pointer number field picks pair 0 or 1.
// - Mode field picks pre/post increment/decrement.
// - Changed counter or true test adds NOP cycle.
// - Add-with-carry updates carry, digit carry, zero.
module idt_decoder import idt_pkg::*; #(
   parameter int PHASES = PHASE_COUNT,
   parameter int WORD   = WORD_W
) (
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic [WORD-1:0]   INSTR_WORD,
   input  wire logic              PTR0_PM,
   input  wire logic              PTR1_PM,
   input  wire logic              COND_TRUE,
   output wire logic [1:0]        PHASE,
   output logic                   FETCH_REQ,
   output logic      [WORD-1:0]   INSTR_REG,
   output logic      [1:0]        INSTR_CLASS,
   output logic      [ADDR_W-1:0] FILE_ADDR,
   output logic      [2:0]        BIT_SEL,
   output logic      [7:0]        BIT_MASK,
   output logic      [LIT_W-1:0]  LITERAL,
   output logic                   DEST_FILE,
   output logic                   PTR_MOVE,
   output logic                   PTR_SEL,
   output logic      [1:0]        PTR_MODE,
   output logic      [2:0]        STATUS_MASK,
   output logic                   ADD_CARRY,
   output logic                   EXEC_NOP,
   output logic                   IND_STALL,
   output logic                   FILE_RD,
   output logic                   FILE_WR,
   output logic                   W_WR
);

   // ---------------------------------------------------------------
   // Elaboration checks and phase generator
   // ---------------------------------------------------------------
   initial begin
      if (WORD != WORD_W)
         $error("idt_decoder: the decode tables serve only 14-bit words");
      if (PHASES != PHASE_COUNT)
         $error("idt_decoder: strobe placement needs four phases per cycle");
   end

   logic wrap;

   idt_phase #(
      .PHASES (PHASES),
      .PH_W   (2)
   ) u_phase (
      .clk    (CLK),
      .reset  (RESET),
      .phase  (PHASE),
      .wrap   (wrap)
   );

   // ---------------------------------------------------------------
   // Instruction register and decoded fields
   // ---------------------------------------------------------------
   logic              load;
   logic [13:0]       ir_reg,      ir_next;
   logic [1:0]        class_reg,   class_next;
   logic [6:0]        addr_reg,    addr_next;
   logic [2:0]        bit_reg,     bit_next;
   logic [7:0]        mask_reg,    mask_next;
   logic [10:0]       lit_reg,     lit_next;
   logic              dest_reg,    dest_next;
   logic              pmove_reg,   pmove_next;
   logic              fsel_reg,    fsel_next;
   logic [1:0]        pmode_reg,   pmode_next;
   logic [2:0]        stat_reg,    stat_next;
   logic              addc_reg,    addc_next;
   logic              two_reg,     two_next;
   logic              skip_reg,    skip_next;
   logic              iop_reg,     iop_next;
   logic              rd_use_reg,  rd_use_next;
   logic              wfile_reg,   wfile_next;
   logic              ww_reg,      ww_next;

   always_comb begin
      logic [13:0] w;
      logic        is_byte;
      logic        is_bit;
      logic        is_lit_alu;
      w          = INSTR_WORD;
      is_byte    = idt_is_byte(w);
      is_bit     = (w[13:12] == CLASS_BIT);
      is_lit_alu = w[13:8] == OP6_MOVLW || w[13:8] == OP6_IORLW || w[13:8] == OP6_ANDLW ||
                   w[13:8] == OP6_XORLW || w[13:8] == OP6_SUBLW || w[13:8] == OP6_ADDLW ||
                   w[13:8] == OP6_RET_LIT;
      ir_next    = ir_reg;
      class_next = class_reg;
      addr_next  = addr_reg;
      bit_next   = bit_reg;
      mask_next  = mask_reg;
      lit_next   = lit_reg;
      dest_next  = dest_reg;
      pmove_next = pmove_reg;
      fsel_next  = fsel_reg;
      pmode_next = pmode_reg;
      stat_next  = stat_reg;
      addc_next  = addc_reg;
      two_next   = two_reg;
      skip_next  = skip_reg;
      iop_next   = iop_reg;
      rd_use_next = rd_use_reg;
      wfile_next = wfile_reg;
      ww_next    = ww_reg;
      if (load) begin
         ir_next    = w;
         class_next = is_byte ? CLASS_BYTE : (is_bit ? CLASS_BIT : CLASS_LITCTL);
         addr_next  = w[ADDR_W-1:0];
         bit_next   = w[BIT_LSB+2:BIT_LSB];
         mask_next  = 8'h01 << w[BIT_LSB+2:BIT_LSB];
         lit_next   = (is_byte || is_bit) ? 11'h000 : w[LIT_W-1:0];
         dest_next  = is_byte && w[DEST_POS];
         pmove_next = (w[13:4] == OP10_PTRMOVE);
         // Indirect moves carry their own pointer number, file operands reach it through the address.
         fsel_next  = pmove_next ? w[PTR_SEL_POS] : w[0];
         pmode_next = w[1:0];
         stat_next  = idt_status(w);
         addc_next  = (w[13:8] == OP6_ADDC);
         two_next   = idt_fixed_two(w);
         skip_next  = idt_is_skip(w);
         iop_next   = pmove_next ||
                      ((is_byte || is_bit) && (w[6:0] == IND0_ADDR || w[6:0] == IND1_ADDR));
         rd_use_next = is_byte || is_bit || pmove_next;
         // Only the listed operand bits are looked at, so don't-care positions alias freely.
         wfile_next = (is_byte && w[DEST_POS]) || (is_bit && !w[11]) ||
                      (pmove_next && w[3]);
         ww_next    = (is_byte && !w[DEST_POS]) || (pmove_next && !w[3]) || is_lit_alu;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ir_reg     <= OP_NOP;
         class_reg  <= CLASS_LITCTL;
         addr_reg   <= 7'h00;
         bit_reg    <= 3'h0;
         mask_reg   <= 8'h01;
         lit_reg    <= 11'h000;
         dest_reg   <= 1'b0;
         pmove_reg  <= 1'b0;
         fsel_reg   <= 1'b0;
         pmode_reg  <= 2'h0;
         stat_reg   <= STAT_NONE;
         addc_reg   <= 1'b0;
         two_reg    <= 1'b0;
         skip_reg   <= 1'b0;
         iop_reg    <= 1'b0;
         rd_use_reg <= 1'b0;
         wfile_reg  <= 1'b0;
         ww_reg     <= 1'b0;
      end else begin
         ir_reg     <= ir_next;
         class_reg  <= class_next;
         addr_reg   <= addr_next;
         bit_reg    <= bit_next;
         mask_reg   <= mask_next;
         lit_reg    <= lit_next;
         dest_reg   <= dest_next;
         pmove_reg  <= pmove_next;
         fsel_reg   <= fsel_next;
         pmode_reg  <= pmode_next;
         stat_reg   <= stat_next;
         addc_reg   <= addc_next;
         two_reg    <= two_next;
         skip_reg   <= skip_next;
         iop_reg    <= iop_next;
         rd_use_reg <= rd_use_next;
         wfile_reg  <= wfile_next;
         ww_reg     <= ww_next;
      end
   end

   // ---------------------------------------------------------------
   // Cycle sequencer and read-modify-write strobes
   // ---------------------------------------------------------------
   idt_state_e st_reg,    st_next;
   logic       nop_reg,   nop_next;
   logic       fetch_reg, fetch_next;
   logic       rd_reg,    rd_next;
   logic       wf_reg,    wf_next;
   logic       ww_s_reg,  ww_s_next;
   logic       nop_o_reg, nop_o_next;
   logic       stl_o_reg, stl_o_next;

   always_comb begin
      logic ind_need;
      logic pc_nop;
      ind_need   = iop_reg && (fsel_reg ? PTR1_PM : PTR0_PM);
      pc_nop     = two_reg || (skip_reg && COND_TRUE);
      st_next    = st_reg;
      nop_next   = nop_reg;
      load       = 1'b0;
      if (wrap) begin
         case (st_reg)
            ST_EXEC: begin
               nop_next = pc_nop;
               if (ind_need)
                  st_next = ST_INDIRECT;
               else if (pc_nop)
                  st_next = ST_NOP;
               else
                  load = 1'b1;
            end
            ST_INDIRECT: begin
               if (nop_reg)
                  st_next = ST_NOP;
               else begin
                  st_next = ST_EXEC;
                  load    = 1'b1;
               end
            end
            ST_NOP: begin
               st_next = ST_EXEC;
               load    = 1'b1;
            end
            default: begin
               st_next = ST_EXEC;
               load    = 1'b1;
            end
         endcase
      end
      // The new word is requested one clock after the load so the fetch path has the whole
      // next instruction cycle to present it.
      fetch_next = load;
      // Reads sit in phase 1 and stores in phase 3 of the first cycle; a pointer stall only
      // waits and never repeats the access.
      rd_next    = (st_reg == ST_EXEC) && !wrap && (PHASE == 2'h0) && rd_use_reg;
      wf_next    = (st_reg == ST_EXEC) && (PHASE == 2'h2) && wfile_reg;
      ww_s_next  = (st_reg == ST_EXEC) && (PHASE == 2'h2) && ww_reg;
      nop_o_next = (st_next == ST_NOP);
      stl_o_next = (st_next == ST_INDIRECT);
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_reg    <= ST_EXEC;
         nop_reg   <= 1'b0;
         fetch_reg <= 1'b1;
         rd_reg    <= 1'b0;
         wf_reg    <= 1'b0;
         ww_s_reg  <= 1'b0;
         nop_o_reg <= 1'b0;
         stl_o_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         nop_reg   <= nop_next;
         fetch_reg <= fetch_next;
         rd_reg    <= rd_next;
         wf_reg    <= wf_next;
         ww_s_reg  <= ww_s_next;
         nop_o_reg <= nop_o_next;
         stl_o_reg <= stl_o_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign FETCH_REQ   = fetch_reg;
   assign INSTR_REG   = ir_reg;
   assign INSTR_CLASS = class_reg;
   assign FILE_ADDR   = addr_reg;
   assign BIT_SEL     = bit_reg;
   assign BIT_MASK    = mask_reg;
   assign LITERAL     = lit_reg;
   assign DEST_FILE   = dest_reg;
   assign PTR_MOVE    = pmove_reg;
   assign PTR_SEL     = fsel_reg;
   assign PTR_MODE    = pmode_reg;
   assign STATUS_MASK = stat_reg;
   assign ADD_CARRY   = addc_reg;
   assign EXEC_NOP    = nop_o_reg;
   assign IND_STALL   = stl_o_reg;
   assign FILE_RD     = rd_reg;
   assign FILE_WR     = wf_reg;
   assign W_WR        = ww_s_reg;

endmodule

/* tb/idt_decoder_sva.sv */
/*
 Concurrent checks on the ports of the decoder top module.
 Assumes one clock domain and the bind statement at the foot of this file.
*/
`timescale 1ns/100ps
module idt_decoder_sva import idt_pkg::*; #(
   parameter int PHASES = PHASE_COUNT,
   parameter int WORD   = WORD_W
) (
   input wire logic              CLK,
   input wire logic              RESET,
   input wire logic              COND_TRUE,
   input wire logic [1:0]        PHASE,
   input wire logic              FETCH_REQ,
   input wire logic [WORD-1:0]   INSTR_REG,
   input wire logic [1:0]        INSTR_CLASS,
   input wire logic [ADDR_W-1:0] FILE_ADDR,
   input wire logic [2:0]        BIT_SEL,
   input wire logic [7:0]        BIT_MASK,
   input wire logic              DEST_FILE,
   input wire logic [2:0]        STATUS_MASK,
   input wire logic              ADD_CARRY,
   input wire logic              EXEC_NOP,
   input wire logic              IND_STALL,
   input wire logic              FILE_RD,
   input wire logic              FILE_WR,
   input wire logic              W_WR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_cycle;
      PHASE == 2'h0 ##1 PHASE == 2'h1 ##1 PHASE == 2'h2 ##1 PHASE == 2'h3;
   endsequence
   sequence s_fixed;
      FETCH_REQ && (INSTR_REG[13:12] == 2'h2 || INSTR_REG == OP_RETURN || INSTR_REG == OP_IRQ_RET ||
                    INSTR_REG == OP_CALL_W || INSTR_REG == OP_BRANCH_W);
   endsequence
   // Pointer-free bit tests only, so that no stall cycle sits between test and no-op.
   sequence s_bit_test;
      FETCH_REQ && INSTR_REG[13:11] == 3'h3 && FILE_ADDR > 7'h01 ##3 1'b1;
   endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   phase_order_a: assert property (FETCH_REQ |-> s_cycle)
      else $error("phase order broken after fetch");
   reg_hold_a: assert property (!FETCH_REQ |-> $stable(INSTR_REG))
      else $error("instruction register changed mid instruction");
   fixed_two_a: assert property (s_fixed |-> ##4 EXEC_NOP [*4] ##1 FETCH_REQ)
      else $error("control transfer not two cycles");
   skip_nop_a: assert property (s_bit_test |=> EXEC_NOP == $past(COND_TRUE) && FETCH_REQ != $past(COND_TRUE))
      else $error("skip result not followed correctly");
   one_cycle_a: assert property (FETCH_REQ && INSTR_CLASS == CLASS_BIT && !INSTR_REG[11] &&
                                 FILE_ADDR > 7'h01 |-> ##4 FETCH_REQ)
      else $error("bit set or clear not one cycle");
   nop_len_a: assert property ($rose(EXEC_NOP) |-> PHASE == 2'h0 ##0 EXEC_NOP [*4] ##1 (FETCH_REQ && !EXEC_NOP))
      else $error("no-op cycle length wrong");
   stall_len_a: assert property ($rose(IND_STALL) |-> IND_STALL [*4] ##1 (!IND_STALL && (FETCH_REQ || EXEC_NOP)))
      else $error("indirect stall length wrong");
   rmw_read_a: assert property (FETCH_REQ && INSTR_CLASS != CLASS_LITCTL |=> FILE_RD)
      else $error("file operand not read");
   dest_sel_a: assert property (FETCH_REQ && INSTR_CLASS == CLASS_BYTE |-> ##3 FILE_WR == DEST_FILE && W_WR != DEST_FILE)
      else $error("result sent to wrong destination");
   addc_flags_a: assert property (ADD_CARRY |-> STATUS_MASK == STAT_ALL && INSTR_CLASS == CLASS_BYTE)
      else $error("add with carry flag mask wrong");
   bit_mask_a: assert property (INSTR_CLASS == CLASS_BIT |-> BIT_MASK == 8'h01 << BIT_SEL)
      else $error("bit mask does not match bit number");
endmodule

bind idt_decoder idt_decoder_sva #(.PHASES(PHASES), .WORD(WORD)) chk_u (
   .CLK(CLK), .RESET(RESET), .COND_TRUE(COND_TRUE), .PHASE(PHASE), .FETCH_REQ(FETCH_REQ),
   .INSTR_REG(INSTR_REG), .INSTR_CLASS(INSTR_CLASS), .FILE_ADDR(FILE_ADDR), .BIT_SEL(BIT_SEL),
   .BIT_MASK(BIT_MASK), .DEST_FILE(DEST_FILE), .STATUS_MASK(STATUS_MASK), .ADD_CARRY(ADD_CARRY),
   .EXEC_NOP(EXEC_NOP), .IND_STALL(IND_STALL), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .W_WR(W_WR));

/* tb/idt_fetch_model.sv */
/*
 Model of the fetch path and datapath status bits facing the decoder.
 Assumes the bench fills prog_q with {cond, ptr1 region, ptr0 region, word} before reset ends.
*/
`timescale 1ns/100ps
module idt_fetch_model import idt_pkg::*; (
   input  wire logic              CLK,
   input  wire logic              FETCH_REQ,
   output logic      [WORD_W-1:0] INSTR_WORD,
   output logic                   PTR0_PM,
   output logic                   PTR1_PM,
   output logic                   COND_TRUE
);
   // ----------------------------------------
   // Prefetch
   // ----------------------------------------
   logic [16:0] prog_q[$];
   logic [16:0] nxt;
   logic [2:0]  pend;
   logic        req_prev;

   initial begin
      INSTR_WORD = OP_NOP;
      PTR0_PM = 1'b0;
      PTR1_PM = 1'b0;
      COND_TRUE = 1'b0;
      pend = 3'h0;
      req_prev = 1'b0;
   end

   // Status of the word just loaded leaves together with the word after it, because
   // the decoder samples it late in the execute cycle of the loaded word.
   always @(negedge CLK) begin
      req_prev <= FETCH_REQ;
      if (FETCH_REQ && !req_prev) begin
         nxt = (prog_q.size() > 0) ? prog_q.pop_front() : 17'h00000;
         {COND_TRUE, PTR1_PM, PTR0_PM} <= pend;
         INSTR_WORD <= nxt[13:0];
         pend <= nxt[16:14];
      end
   end
endmodule

/* tb/tb_instruction_decode_timing.sv */
/*
 Self-checking bench for the decoder: random words from opcode templates, scoreboard on fetch.
 Assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module tb_instruction_decode_timing import idt_pkg::*; ;
   logic        CLK;
   logic        RESET;
   logic [13:0] INSTR_WORD;
   logic        PTR0_PM;
   logic        PTR1_PM;
   logic        COND_TRUE;
   logic [1:0]  PHASE;
   logic        FETCH_REQ;
   logic [13:0] INSTR_REG;
   logic [1:0]  INSTR_CLASS;
   logic [6:0]  FILE_ADDR;
   logic [2:0]  BIT_SEL;
   logic [7:0]  BIT_MASK;
   logic [10:0] LITERAL;
   logic        DEST_FILE;
   logic        PTR_MOVE;
   logic        PTR_SEL;
   logic [1:0]  PTR_MODE;
   logic [2:0]  STATUS_MASK;
   logic        ADD_CARRY;
   logic        EXEC_NOP;
   logic        IND_STALL;
   logic        FILE_RD;
   logic        FILE_WR;
   logic        W_WR;
   int          errors = 0;
   int          cmp_count = 0;
   int          cnt = 0;
   int          sc = 0;
   int          nc = 0;
   logic        done = 1'b0;
   logic        have = 1'b0;
   logic [15:0] cur;
   logic [13:0] w;
   logic [15:0] exp_q[$];

   localparam logic [13:0] TBASE [13] = '{14'h0100, 14'h0080, 14'h3d00, 14'h1000, 14'h2000, 14'h3000, 14'h0008,
                                          14'h0009, 14'h000a, 14'h000b, 14'h0010, 14'h0700, 14'h1800};
   localparam logic [13:0] TMASK [13] = '{14'h0eff, 14'h007f, 14'h00ff, 14'h0fff, 14'h1fff, 14'h0fff, 14'h0000,
                                          14'h0000, 14'h0000, 14'h0000, 14'h0007, 14'h0081, 14'h0781};

   idt_decoder dut_u (
      .CLK(CLK), .RESET(RESET), .INSTR_WORD(INSTR_WORD), .PTR0_PM(PTR0_PM), .PTR1_PM(PTR1_PM),
      .COND_TRUE(COND_TRUE), .PHASE(PHASE), .FETCH_REQ(FETCH_REQ), .INSTR_REG(INSTR_REG),
      .INSTR_CLASS(INSTR_CLASS), .FILE_ADDR(FILE_ADDR), .BIT_SEL(BIT_SEL), .BIT_MASK(BIT_MASK),
      .LITERAL(LITERAL), .DEST_FILE(DEST_FILE), .PTR_MOVE(PTR_MOVE), .PTR_SEL(PTR_SEL),
      .PTR_MODE(PTR_MODE), .STATUS_MASK(STATUS_MASK), .ADD_CARRY(ADD_CARRY), .EXEC_NOP(EXEC_NOP),
      .IND_STALL(IND_STALL), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .W_WR(W_WR));

   idt_fetch_model fetch_u (
      .CLK(CLK), .FETCH_REQ(FETCH_REQ), .INSTR_WORD(INSTR_WORD),
      .PTR0_PM(PTR0_PM), .PTR1_PM(PTR1_PM), .COND_TRUE(COND_TRUE));

   // ----------------------------------------
   // Reference and helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [1:0] cls(input logic [13:0] v);
      if ((v[13:12] == 2'h0 && v[11:8] != 4'h0) || v[13:7] == 7'h01 ||
          v[13:8] inside {6'h3d, 6'h3b, 6'h35, 6'h36, 6'h37})
         cls = CLASS_BYTE;
      else if (v[13:12] == 2'h1)
         cls = CLASS_BIT;
      else
         cls = CLASS_LITCTL;
   endfunction

   // Returns {extra indirect cycle, forced no-op cycle} for one stimulus entry.
   function automatic logic [1:0] extra(input logic [16:0] e);
      logic [13:0] v;
      logic        pm;
      logic        nop;
      v = e[13:0];
      pm = (v[13:4] == 10'h001) ? e[14 + v[2]] :
           (cls(v) != CLASS_LITCTL && v[6:1] == 6'h00) ? e[14 + v[0]] : 1'b0;
      nop = v[13:12] == 2'h2 || v[13:9] == 5'h19 || v[13:8] == 6'h34 || v inside {14'h0008, 14'h0009,
            14'h000a, 14'h000b} || (e[16] && (v[13:8] == 6'h0b || v[13:8] == 6'h0f || v[13:11] == 3'h3));
      extra = {pm, nop};
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, stimulus, scoreboard
   // ----------------------------------------
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   initial begin
      logic [31:0] s;
      logic [16:0] e;
      RESET = 1'b1;
      s = 32'h7d303b47;
      for (int i = 0; i < 130; i++) begin
         s = lfsr_next(s);
         e = {s[16:14], TBASE[i % 13] | (s[13:0] & TMASK[i % 13])};
         fetch_u.prog_q.push_back(e);
         exp_q.push_back({extra(e), e[13:0]});
      end
      repeat (4) @(negedge CLK);
      // Released by a non-blocking write so the scoreboard at this edge still sees reset.
      RESET <= 1'b0;
      wait (done);
      end_sim;
   end

   // A program of 130 words takes at most about 31 us even if every word runs three cycles.
   initial begin
      #60000;
      errors++;
      end_sim;
   end

   always @(negedge CLK) begin
      if (!RESET && !done) begin
         if (FETCH_REQ) begin
            if (have) begin
               check("cycles", 16'(cnt), 16'(4 * (1 + cur[15] + cur[14])));
               check("stall", 16'(sc), 16'(4 * cur[15]));
               check("noop", 16'(nc), 16'(4 * cur[14]));
            end
            if (exp_q.size() == 0)
               done = 1'b1;
            else begin
               cur = exp_q.pop_front();
               w = cur[13:0];
               check("word", 16'(INSTR_REG), 16'(w));
               check("class", 16'(INSTR_CLASS), 16'(cls(w)));
               check("addr", 16'(FILE_ADDR), 16'(w[6:0]));
               check("bitnum", 16'({BIT_SEL, BIT_MASK}), 16'({w[9:7], 8'h01 << w[9:7]}));
               check("dest", 16'(DEST_FILE), 16'(cls(w) == CLASS_BYTE && w[7]));
               check("literal", 16'(LITERAL), 16'(cls(w) == CLASS_LITCTL ? w[10:0] : 11'h000));
               check("ptrsel", 16'({PTR_MOVE, PTR_SEL}), 16'({w[13:4] == 10'h001, w[13:4] == 10'h001 ? w[2] : w[0]}));
               check("ptrmode", 16'(PTR_MODE), 16'(w[1:0]));
               check("addc", 16'(ADD_CARRY), 16'(w[13:8] == 6'h3d));
               have = 1'b1;
            end
            cnt = 1;
            sc = 0;
            nc = 0;
         end else begin
            cnt++;
            sc += int'(IND_STALL === 1'b1);
            nc += int'(EXEC_NOP === 1'b1);
         end
      end
   end
endmodule
